// >>> krlt_pkg.sv
// Purpose : Shared constants for the link training control register slice
// Assumes : 32-bit APB data, one aligned word per register index
// Notes   : Byte address of a register is four times its index
package krlt_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [13:0] IDX_CONFIG   = 14'h04D0; // Training options
    localparam logic [13:0] IDX_COMMAND  = 14'h04D1; // Self-clearing commands
    localparam logic [13:0] IDX_STATUS   = 14'h04D2; // Engine status
    localparam logic [13:0] IDX_OVERRIDE = 14'h04D4; // Coefficient override word
    localparam logic [13:0] IDX_IRQ_STAT = 14'h04E0; // Sticky event flags
    localparam logic [13:0] IDX_IRQ_MASK = 14'h04E1; // Event enables

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_PARTNER_OVR  = 16; // Partner coefficient override enable
    localparam int CFG_LOCAL_OVR    = 17; // Local coefficient override enable
    localparam int CFG_MAIN_TAP     = 18; // Main tap exercise
    localparam int CFG_DFE_BYPASS   = 19; // Equalizer bypass
    localparam int CFG_HOLD_LO      = 20; // Equalizer hold field, low bit
    localparam int CFG_CTLE_MODE    = 22; // Linear equalizer manual mode
    localparam int CFG_CTLE_LO      = 24; // Manual linear equalizer value, low bit
    localparam int CFG_VGA_LO       = 29; // Manual gain value, low bit
    localparam int CMD_RESTART      = 0;  // Restart start-up protocol
    localparam int CMD_PARTNER_NEW  = 4;  // Send partner coefficients
    localparam int CMD_LOCAL_NEW    = 8;  // Load local coefficients
    localparam int OVR_PARTNER_LO   = 0;  // Partner commands, low bit of byte
    localparam int OVR_LOCAL_LO     = 16; // Local coefficients, low bit of byte
    localparam int STS_RX_TRAINED   = 0;  // Receiver trained
    localparam int STS_FRAME_LOCK   = 1;  // Frame delineation found
    localparam int STS_STARTUP      = 2;  // Start-up protocol running
    localparam int STS_FAILURE      = 3;  // Training failure
    localparam int NUM_STS          = 4;  // Status inputs from the engine

    // ------------------------------------------------------------------
    // Hold field codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] HOLD_FREE       = 2'h0; // All taps adapt
    localparam logic [1:0] HOLD_FREEZE     = 2'h1; // All taps frozen
    localparam logic       RST_PARTNER_OVR = 1'h0;
    localparam logic       RST_LOCAL_OVR   = 1'h0;
    localparam logic       RST_MAIN_TAP    = 1'h0;
    localparam logic       RST_BYPASS_SIM  = 1'h1;
    localparam logic       RST_BYPASS_HW   = 1'h0;
    localparam logic [1:0] RST_HOLD        = 2'h1;
    localparam logic       RST_MODE_SIM    = 1'h1;
    localparam logic       RST_MODE_HW     = 1'h0;
    localparam logic [4:0] RST_CTLE        = 5'h01;
    localparam logic [2:0] RST_VGA_SIM     = 3'h4;
    localparam logic [2:0] RST_VGA_HW      = 3'h7;
    localparam logic [7:0] RST_COEF        = 8'h00;
    localparam logic [3:0] RST_IRQ_MASK    = 4'h0;

    // Interrupt event positions
    localparam int IRQ_TRAINED   = 0; // Receiver became trained
    localparam int IRQ_LOCK_LOST = 1; // Frame lock dropped
    localparam int IRQ_DONE      = 2; // Start-up protocol finished
    localparam int IRQ_FAIL      = 3; // Failure detected

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

endpackage : krlt_pkg

// >>> krlt_sync.sv
// Purpose : Two-flop synchroniser for engine status levels
// Assumes : Inputs are levels from another timing domain
// Notes   : First stage feeds only the second stage
`timescale 1ns/100ps
module krlt_sync
    import krlt_pkg::*;
#(
    parameter int WIDTH = NUM_STS
)
(
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Per-bit double flop
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q; // First stage, read by second stage only

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            // Capture then retime one bit
            always_ff @(posedge core_clk)
            begin
                if (srst)
                begin
                    meta_q[gi]   <= 1'b0;
                    sync_out[gi] <= 1'b0;
                end
                else
                begin
                    meta_q[gi]   <= async_in[gi];
                    sync_out[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule // krlt_sync

// >>> krlt_regs.sv
// Purpose : APB register slice controlling a backplane link training engine
// Assumes : Engine status levels arrive from another domain and are synchronised
// Notes   : Access phase lasts two cycles; read data and pready come from flops
`timescale 1ns/100ps
module krlt_regs
    import krlt_pkg::*;
#(
    parameter bit SIM_DEFAULTS = 1'b0,  // Selects simulation reset values
    parameter int ADDR_W       = 16     // APB address width
)
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    // Engine status levels
    input  wire logic              eng_rx_trained,
    input  wire logic              eng_frame_lock,
    input  wire logic              eng_startup_busy,
    input  wire logic              eng_training_failure,
    // Engine controls
    output logic                   main_tap_exercise_enable,
    output logic                   dfe_adapt_enable,
    output logic                   dfe_freeze_all,
    output logic                   ctle_manual_mode,
    output logic      [4:0]        ctle_manual_value,
    output logic      [2:0]        vga_manual_value,
    output logic                   partner_coef_override_enable,
    output logic                   local_coef_override_enable,
    output logic      [7:0]        partner_coef_cmd,
    output logic      [7:0]        local_coef_value,
    output logic                   restart_state_variable,
    output logic                   partner_coef_send,
    output logic                   local_coef_load,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        partner_ovr;   // Partner override enable
        logic        local_ovr;     // Local override enable
        logic        main_tap;      // Main tap exercise
        logic        bypass;        // Equalizer bypass
        logic [1:0]  hold;          // Equalizer hold code
        logic        mode;          // Manual equalizer mode
        logic [4:0]  ctle;          // Manual linear equalizer value
        logic [2:0]  vga;           // Manual gain value
        logic [7:0]  partner_coef;  // Override word low byte
        logic [7:0]  local_coef;    // Override word bits 23:16
        logic [2:0]  cmd;           // Command bits, one cycle high
        logic [3:0]  irq_stat;      // Sticky events
        logic [3:0]  irq_mask;      // Event enables
        logic [3:0]  sts_prev;      // Status seen last cycle
        logic        ready;         // APB pready
        logic        slverr;        // APB pslverr
        logic [31:0] rdata;         // APB read data
        logic        o_main_tap;    // Registered engine controls
        logic        o_adapt;
        logic        o_freeze;
        logic        o_mode;
        logic [4:0]  o_ctle;
        logic [2:0]  o_vga;
        logic        o_restart;
        logic        o_send;
        logic        o_load;
        logic        o_irq;
    } krlt_state_t;

    krlt_state_t st_q;             // Current state
    krlt_state_t st_d;             // Next state
    logic [NUM_STS-1:0] sts_async; // Raw status levels
    logic [NUM_STS-1:0] sts;       // Synchronised status
    logic [31:0] wmask;            // Byte-lane write mask

    // ------------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------------
    assign sts_async = {eng_training_failure, eng_startup_busy,
                        eng_frame_lock, eng_rx_trained};

    krlt_sync #(.WIDTH(NUM_STS)) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (sts_async),
        .sync_out (sts)
    );

    // ------------------------------------------------------------------
    // Byte lane expansion
    // ------------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_lane
            assign wmask[gb*8 +: 8] = {8{pstrb[gb]}};
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic        acc;      // Access cycle waiting for answer
        logic        done;     // Completing edge of a transfer
        logic        wr;       // Write commit
        logic [13:0] idx;      // Register index
        logic        hit;      // Mapped index
        logic [31:0] cfg;      // Merged config word
        logic [31:0] ovr;      // Merged override word
        logic [31:0] rd;       // Read mux
        logic [3:0]  ev;       // Events this cycle
        acc  = 1'b0;
        done = 1'b0;
        wr   = 1'b0;
        idx  = 14'h0000;
        hit  = 1'b0;
        cfg  = 32'h0000_0000;
        ovr  = 32'h0000_0000;
        rd   = 32'h0000_0000;
        ev   = 4'h0;
        st_d = st_q;

        // Decode: word index from the byte address
        idx  = paddr[15:2];
        hit  = (idx == IDX_CONFIG) || (idx == IDX_COMMAND) || (idx == IDX_STATUS) ||
               (idx == IDX_OVERRIDE) || (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
        acc  = psel && penable && !st_q.ready;
        done = psel && penable && st_q.ready;
        wr   = done && pwrite && !st_q.slverr;

        // Current register images
        cfg = {st_q.vga, st_q.ctle, 1'b0, st_q.mode, st_q.hold, st_q.bypass,
               st_q.main_tap, st_q.local_ovr, st_q.partner_ovr, 16'h0000};
        ovr = {8'h00, st_q.local_coef, 8'h00, st_q.partner_coef};

        // Read mux; status reflects the synchronised engine levels
        case (idx)
            IDX_CONFIG:   rd = cfg;
            IDX_COMMAND:  rd = {23'h000000, st_q.cmd[2], 3'h0, st_q.cmd[1], 3'h0, st_q.cmd[0]};
            IDX_STATUS:   rd = {28'h0000000, sts};
            IDX_OVERRIDE: rd = ovr;
            IDX_IRQ_STAT: rd = {28'h0000000, st_q.irq_stat};
            IDX_IRQ_MASK: rd = {28'h0000000, st_q.irq_mask};
            default:      rd = 32'h0000_0000;
        endcase

        // APB answer: one wait state, then pready with registered data
        st_d.ready  = acc;
        st_d.slverr = acc && !hit;
        if (acc)
        begin
            st_d.rdata = hit ? rd : 32'h0000_0000;
        end

        // Commands last exactly one cycle
        st_d.cmd = 3'h0;

        // Register writes
        if (wr)
        begin
            case (idx)
                IDX_CONFIG:
                begin
                    cfg = (cfg & ~wmask) | (pwdata & wmask);
                    st_d.partner_ovr = cfg[CFG_PARTNER_OVR];
                    st_d.local_ovr   = cfg[CFG_LOCAL_OVR];
                    st_d.main_tap    = cfg[CFG_MAIN_TAP];
                    st_d.bypass      = cfg[CFG_DFE_BYPASS];
                    st_d.hold        = cfg[CFG_HOLD_LO +: 2];
                    st_d.mode        = cfg[CFG_CTLE_MODE];
                    st_d.ctle        = cfg[CFG_CTLE_LO +: 5];
                    st_d.vga         = cfg[CFG_VGA_LO +: 3];
                end
                IDX_COMMAND:
                begin
                    // Only a one starts a command; zero leaves operation alone
                    st_d.cmd[0] = pstrb[0] && pwdata[CMD_RESTART];
                    st_d.cmd[1] = pstrb[0] && pwdata[CMD_PARTNER_NEW];
                    st_d.cmd[2] = pstrb[1] && pwdata[CMD_LOCAL_NEW];
                end
                IDX_OVERRIDE:
                begin
                    ovr = (ovr & ~wmask) | (pwdata & wmask);
                    st_d.partner_coef = ovr[OVR_PARTNER_LO +: 8];
                    st_d.local_coef   = ovr[OVR_LOCAL_LO +: 8];
                end
                IDX_IRQ_MASK:
                begin
                    if (pstrb[0])
                    begin
                        st_d.irq_mask = pwdata[3:0];
                    end
                end
                default:
                begin
                    st_d.cmd = 3'h0;
                end
            endcase
        end

        // Events from synchronised status edges
        ev[IRQ_TRAINED]   = sts[STS_RX_TRAINED] && !st_q.sts_prev[STS_RX_TRAINED];
        ev[IRQ_LOCK_LOST] = !sts[STS_FRAME_LOCK] && st_q.sts_prev[STS_FRAME_LOCK];
        ev[IRQ_DONE]      = !sts[STS_STARTUP] && st_q.sts_prev[STS_STARTUP];
        ev[IRQ_FAIL]      = sts[STS_FAILURE] && !st_q.sts_prev[STS_FAILURE];
        st_d.sts_prev     = sts;

        // Write-one-to-clear, a new event wins over the clear
        if (wr && (idx == IDX_IRQ_STAT) && pstrb[0])
        begin
            st_d.irq_stat = st_q.irq_stat & ~pwdata[3:0];
        end
        st_d.irq_stat = st_d.irq_stat | ev;

        // Registered engine controls
        st_d.o_main_tap = st_q.main_tap;
        st_d.o_adapt    = !st_q.bypass;
        st_d.o_freeze   = !st_q.bypass && (st_q.hold == HOLD_FREEZE);
        st_d.o_mode     = st_q.mode;
        st_d.o_ctle     = st_q.mode ? st_q.ctle : 5'h00;
        st_d.o_vga      = st_q.mode ? st_q.vga : 3'h0;
        st_d.o_restart  = st_d.cmd[0];
        st_d.o_send     = st_d.cmd[1] && st_q.partner_ovr;
        st_d.o_load     = st_d.cmd[2] && st_q.local_ovr;
        st_d.o_irq      = |(st_d.irq_stat & st_d.irq_mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_q              <= '0;
            st_q.partner_ovr  <= RST_PARTNER_OVR;
            st_q.local_ovr    <= RST_LOCAL_OVR;
            st_q.main_tap     <= RST_MAIN_TAP;
            st_q.bypass       <= SIM_DEFAULTS ? RST_BYPASS_SIM : RST_BYPASS_HW;
            st_q.hold         <= RST_HOLD;
            st_q.mode         <= SIM_DEFAULTS ? RST_MODE_SIM : RST_MODE_HW;
            st_q.ctle         <= RST_CTLE;
            st_q.vga          <= SIM_DEFAULTS ? RST_VGA_SIM : RST_VGA_HW;
            st_q.partner_coef <= RST_COEF;
            st_q.local_coef   <= RST_COEF;
            st_q.irq_mask     <= RST_IRQ_MASK;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flop
    // ------------------------------------------------------------------
    assign pready                       = st_q.ready;
    assign prdata                       = st_q.rdata;
    assign pslverr                      = st_q.slverr;
    assign main_tap_exercise_enable     = st_q.o_main_tap;
    assign dfe_adapt_enable             = st_q.o_adapt;
    assign dfe_freeze_all               = st_q.o_freeze;
    assign ctle_manual_mode             = st_q.o_mode;
    assign ctle_manual_value            = st_q.o_ctle;
    assign vga_manual_value             = st_q.o_vga;
    assign partner_coef_override_enable = st_q.partner_ovr;
    assign local_coef_override_enable   = st_q.local_ovr;
    assign partner_coef_cmd             = st_q.partner_coef;
    assign local_coef_value             = st_q.local_coef;
    assign restart_state_variable       = st_q.o_restart;
    assign partner_coef_send            = st_q.o_send;
    assign local_coef_load              = st_q.o_load;
    assign irq                          = st_q.o_irq;

endmodule // krlt_regs

// >>> krlt_regs_checker.sv
// Purpose : Port assertions for the training register slice
// Assumes : One wait state per APB access, full byte strobes
// Notes   : Bound from the testbench top file
`timescale 1ns/100ps
module krlt_regs_checker
    import krlt_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input wire logic              core_clk,
    input wire logic              srst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              main_tap_exercise_enable,
    input wire logic              dfe_adapt_enable,
    input wire logic              dfe_freeze_all,
    input wire logic              ctle_manual_mode,
    input wire logic [4:0]        ctle_manual_value,
    input wire logic [2:0]        vga_manual_value,
    input wire logic              partner_coef_override_enable,
    input wire logic              restart_state_variable,
    input wire logic              partner_coef_send
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Full-word write committing to one register index
    sequence s_wr(logic [13:0] idx);
        psel && penable && pready && pwrite && pstrb == 4'hF && paddr == {idx, 2'h0};
    endsequence
    // Config controls follow the written word two edges after commit
    property p_main_tap;
        s_wr(IDX_CONFIG) |-> ##2 main_tap_exercise_enable == $past(pwdata[CFG_MAIN_TAP], 2);
    endproperty
    a_main_tap: assert property (p_main_tap) else $error("main tap enable wrong");
    property p_bypass;
        s_wr(IDX_CONFIG) |-> ##2 dfe_adapt_enable == !$past(pwdata[CFG_DFE_BYPASS], 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("adapt enable wrong");
    property p_freeze;
        s_wr(IDX_CONFIG) |-> ##2 dfe_freeze_all ==
            ($past(pwdata[21:20], 2) == HOLD_FREEZE && !$past(pwdata[CFG_DFE_BYPASS], 2));
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze wrong");
    property p_hold_ignored;
        dfe_freeze_all |-> dfe_adapt_enable;
    endproperty
    a_hold_ignored: assert property (p_hold_ignored) else $error("freeze under bypass");
    property p_manual_zero;
        !ctle_manual_mode |-> ctle_manual_value == 5'h00 && vga_manual_value == 3'h0;
    endproperty
    a_manual_zero: assert property (p_manual_zero) else $error("manual value leaks");
    // Command pulses last exactly one cycle after the commit edge
    property p_restart;
        s_wr(IDX_COMMAND) ##0 pwdata[CMD_RESTART] |=> restart_state_variable ##1 !restart_state_variable;
    endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    property p_send;
        s_wr(IDX_COMMAND) ##0 (pwdata[CMD_PARTNER_NEW] && partner_coef_override_enable)
            |=> partner_coef_send ##1 !partner_coef_send;
    endproperty
    a_send: assert property (p_send) else $error("send pulse wrong");
    property p_nosend;
        s_wr(IDX_COMMAND) ##0 !partner_coef_override_enable |=> !partner_coef_send;
    endproperty
    a_nosend: assert property (p_nosend) else $error("send without enable");
endmodule // krlt_regs_checker

// >>> krlt_engine_model.sv
// Purpose : Training engine model driving status levels
// Assumes : Restart pulse from the slice starts a run
// Notes   : Failure level follows fail_req from the bench
`timescale 1ns/100ps
module krlt_engine_model
(
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic restart_state_variable,
    input  wire logic fail_req,
    output logic      eng_rx_trained,
    output logic      eng_frame_lock,
    output logic      eng_startup_busy,
    output logic      eng_training_failure
);
    logic     run_q; // Start-up run seen
    logic [4:0] cnt_q; // Cycles into the run
    // Restart begins a new run; lock at 8 cycles, trained at 20
    always_ff @(posedge core_clk)
    begin
        if (srst)
            run_q <= 1'b0;
        else if (restart_state_variable)
            run_q <= 1'b1;
        cnt_q <= (srst || restart_state_variable) ? 5'h00 : (cnt_q < 5'h14 ? cnt_q + 5'h01 : cnt_q);
    end
    assign eng_startup_busy     = run_q && cnt_q < 5'h14;
    assign eng_frame_lock       = run_q && cnt_q >= 5'h08;
    assign eng_rx_trained       = run_q && cnt_q >= 5'h14;
    assign eng_training_failure = fail_req;
endmodule // krlt_engine_model

// >>> kr_link_training_control_regs_test.sv
// Purpose : Self-checking bench for the training register slice
// Assumes : Hardware reset values, one wait state per access
// Notes   : Engine status comes from the engine model
`timescale 1ns/100ps
module kr_link_training_control_regs_test
    import krlt_pkg::*;
;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, fail_req, se, irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [3:0] pstrb;
    logic eng_rx_trained, eng_frame_lock, eng_startup_busy, eng_training_failure;
    logic main_tap_exercise_enable, dfe_adapt_enable, dfe_freeze_all, ctle_manual_mode;
    logic [4:0] ctle_manual_value;
    logic [2:0] vga_manual_value, k;
    logic partner_coef_override_enable, local_coef_override_enable;
    logic [7:0] partner_coef_cmd, local_coef_value;
    logic restart_state_variable, partner_coef_send, local_coef_load;
    int err_count, compares, n;
    krlt_regs krlt_regs_i (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .eng_rx_trained, .eng_frame_lock, .eng_startup_busy,
        .eng_training_failure, .main_tap_exercise_enable, .dfe_adapt_enable, .dfe_freeze_all,
        .ctle_manual_mode, .ctle_manual_value, .vga_manual_value, .partner_coef_override_enable,
        .local_coef_override_enable, .partner_coef_cmd, .local_coef_value,
        .restart_state_variable, .partner_coef_send, .local_coef_load, .irq);
    krlt_engine_model krlt_engine_model_i (.core_clk, .srst, .restart_state_variable,
        .fail_req, .eng_rx_trained, .eng_frame_lock, .eng_startup_busy, .eng_training_failure);
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; returns at the edge that samples pready
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_count++;
            wrap_up();
        end
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] outs();
        return {20'h0, main_tap_exercise_enable, dfe_adapt_enable, dfe_freeze_all,
            ctle_manual_mode, ctle_manual_value, vga_manual_value};
    endfunction
    initial
    begin
        {srst, psel, penable, pwrite, fail_req} = 5'h10;
        paddr = 16'h0000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, IDX_CONFIG, 32'h0);
        chk(rd, 32'hE1100000);
        #1 chk(outs(), 32'h600);
        for (int i = 0; i < 8; i++)
        begin
            k = i[2:0];
            w = {3'h5, 5'h15, 1'b1, k[1], k[1:0], k[2], k[0], 2'h0, 16'hFFFF};
            apb(1'b1, IDX_CONFIG, w);
            apb(1'b0, IDX_CONFIG, 32'h0);
            chk(rd, w & 32'hFF7F0000);
            #1 chk(outs(), {20'h0, k[0], !k[2], !k[2] && k[1:0] == 2'h1, k[1],
                k[1] ? 5'h15 : 5'h00, k[1] ? 3'h5 : 3'h0});
        end
        $display("config test done");
        apb(1'b1, IDX_OVERRIDE, 32'hFFABFFCD);
        apb(1'b0, IDX_OVERRIDE, 32'h0);
        chk(rd, 32'h00AB00CD);
        #1 chk({16'h0, partner_coef_cmd, local_coef_value}, 32'hCDAB);
        apb(1'b1, IDX_CONFIG, 32'h0);
        apb(1'b1, IDX_COMMAND, 32'h110);
        #1 chk({30'h0, partner_coef_send, local_coef_load}, 32'h0);
        apb(1'b1, IDX_CONFIG, 32'h00030000);
        #1 chk({30'h0, partner_coef_override_enable, local_coef_override_enable}, 32'h3);
        apb(1'b1, IDX_COMMAND, 32'h110);
        #1 chk({30'h0, partner_coef_send, local_coef_load}, 32'h3);
        apb(1'b0, IDX_COMMAND, 32'h0);
        chk(rd, 32'h0);
        $display("command test done");
        apb(1'b1, IDX_COMMAND, 32'h1);
        #1 chk({31'h0, restart_state_variable}, 32'h1);
        repeat (3) @(posedge core_clk);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rd, 32'h4);
        repeat (30) @(posedge core_clk);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rd, 32'h3);
        fail_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b1, IDX_STATUS, 32'h0);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rd, 32'hB);
        $display("status test done");
        apb(1'b0, IDX_IRQ_STAT, 32'h0);
        chk({rd[31:1], irq}, 32'hC);
        apb(1'b1, IDX_IRQ_MASK, 32'h1);
        @(posedge core_clk);
        #1 chk({31'h0, irq}, 32'h1);
        apb(1'b1, IDX_IRQ_STAT, 32'h1);
        @(posedge core_clk);
        #1 chk({31'h0, irq}, 32'h0);
        apb(1'b0, IDX_IRQ_STAT, 32'h0);
        chk(rd, 32'hC);
        apb(1'b0, 14'h0100, 32'h0);
        chk({rd[31:1], se}, 32'h1);
        apb(1'b1, IDX_COMMAND, 32'h1);
        repeat (5) @(posedge core_clk);
        apb(1'b0, IDX_IRQ_STAT, 32'h0);
        chk(rd, 32'hE);
        $display("interrupt test done");
        wrap_up();
    end
endmodule // kr_link_training_control_regs_test
bind krlt_regs krlt_regs_checker #(.ADDR_W(ADDR_W)) krlt_regs_checker_i (.core_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .main_tap_exercise_enable,
    .dfe_adapt_enable, .dfe_freeze_all, .ctle_manual_mode, .ctle_manual_value,
    .vga_manual_value, .partner_coef_override_enable, .restart_state_variable,
    .partner_coef_send);
